// File: verilog/twc_defines.svh
// Offsets, field positions, reset values and timing figures of the config port
`ifndef TWC_DEFINES_SVH
`define TWC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------------------
`define TWC_FRAME_BITS     5'd16
`define TWC_FRAME_LAST     5'd15
`define TWC_ADDR_MSB       13
`define TWC_ADDR_LSB       10
`define TWC_DATA_MSB       9
`define TWC_NUM_REGS       16

// ----------------------------------------------------------------------------
// Configuration register file
// ----------------------------------------------------------------------------
`define TWC_CTRL1_ADDR     4'h0
`define TWC_CTRL1_STANDBY_REQUEST_N     9
`define TWC_CTRL1_SWRST    8
`define TWC_CFG_DEFAULT    10'h000

// ----------------------------------------------------------------------------
// Avalon register map (byte addresses)
// ----------------------------------------------------------------------------
`define TWC_AVM_CTRL       8'h00
`define TWC_AVM_STATUS     8'h04
`define TWC_AVM_LAST       8'h08
`define TWC_AVM_CFG_BASE   8'h40
`define TWC_CTRL_PORTEN    0
`define TWC_CTRL_RESET     1'h1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TWC_SYS_MHZ        125
`define TWC_SCLK_MAX_MHZ   40
`define TWC_FRAME_MIN_CYC  ((16 * `TWC_SYS_MHZ + `TWC_SCLK_MAX_MHZ - 1) / `TWC_SCLK_MAX_MHZ)

`endif

// File: verilog/twc_pkg.sv
// Types shared by the three-wire config port
package twc_pkg;
    typedef logic [9:0]  twc_data_t;
    typedef logic [3:0]  twc_addr_t;
    typedef logic [15:0] twc_frame_t;
    typedef enum logic [0:0]
    {
        TWC_BUS_IDLE = 1'b0,
        TWC_BUS_ACK  = 1'b1
    } twc_bus_state_t;
endpackage

// File: verilog/twc_sync.sv
// Two-flop level synchroniser, one lane per bit
`timescale 1ns/1ps
module twc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q  <= '0;
            syncOut <= '0;
        end
        else
        begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // twc_sync

// File: verilog/twc_rx.sv
// Link-domain shift receiver for 16-bit serial write frames
`timescale 1ns/1ps
`include "twc_defines.svh"
module twc_rx
    import twc_pkg::*;
(
    input  wire logic linkClk,
    input  wire logic frameRst,
    input  wire logic linkRst,
    input  wire logic serialData,
    output twc_frame_t frameWord_q,
    output logic       frameTgl_q
);
    logic [4:0]  bitCnt_q;
    logic [14:0] shift_q;
    wire         bitTake = bitCnt_q != `TWC_FRAME_BITS;
    wire         lastBit = bitCnt_q == `TWC_FRAME_LAST;

    // Counter restarts whenever select is high, so a frame opens at the
    // first clock edge after select falls and short frames vanish
    always_ff @(posedge linkClk or posedge frameRst)
    begin
        if (frameRst)
        begin
            bitCnt_q <= 5'h00;
            shift_q  <= 15'h0000;
        end
        else if (bitTake)
        begin
            bitCnt_q <= bitCnt_q + 5'h01;
            shift_q  <= {shift_q[13:0], serialData};
        end
    end

    // Word and toggle survive select; the word is stable until the next frame
    always_ff @(posedge linkClk or posedge linkRst)
    begin
        if (linkRst)
        begin
            frameWord_q <= 16'h0000;
            frameTgl_q  <= 1'b0;
        end
        else if (lastBit)
        begin
            frameWord_q <= {shift_q, serialData};
            frameTgl_q  <= ~frameTgl_q;
        end
    end

    chk_bits_taken: assert property (@(posedge linkClk) disable iff (frameRst)
        lastBit |=> frameTgl_q != $past(frameTgl_q))
        else $error("frame toggle missing after sixteenth bit");

    chk_extra_ignored: assert property (@(posedge linkClk) disable iff (frameRst)
        !bitTake |=> $stable(frameWord_q) && $stable(frameTgl_q))
        else $error("bits beyond sixteen changed the frame");
endmodule // twc_rx

// File: verilog/twc_top.sv
// Three-wire write-only configuration port with reset and standby control
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "twc_defines.svh"
module twc_top
    import twc_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic         serialClk,
    input  wire logic         selectN,
    input  wire logic         serial_write_data,
    input  wire logic         serial_clock_polarity_strap,
    input  wire logic         resetPinN,
    input  wire logic         standby_request_n,
    input  wire logic [7:0]   avsAddress,
    input  wire logic         avsRead,
    input  wire logic         avsWrite,
    input  wire logic [31:0]  avsWritedata,
    output logic      [31:0]  avsReaddata,
    output logic              avsWaitrequest,
    output logic              standbyActive,
    output logic      [159:0] cfgRegs
);

    // ------------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------------
    // The strap is a board level that never moves in operation, so it may
    // steer the clock inversion directly; a strap change mid-frame corrupts it
    wire        linkClk  = serialClk ^ serial_clock_polarity_strap;
    // Select high holds the receiver cleared, dropping partial frames
    wire        frameRst = selectN | ~arst_n;
    wire        linkRst  = ~arst_n;
    twc_frame_t frameWord;
    logic       frameTgl;

    twc_rx u_rx (
        .linkClk     (linkClk),
        .frameRst    (frameRst),
        .linkRst     (linkRst),
        .serialData  (serial_write_data),
        .frameWord_q (frameWord),
        .frameTgl_q  (frameTgl)
    );

    // ------------------------------------------------------------------------
    // Crossing into the system clock
    // ------------------------------------------------------------------------
    // Of the frame, only the toggle crosses through flops; the word is held still by the
    // receiver until at least one more full frame, far longer than the sync
    logic [3:0] syncOut;
    logic       tglSync;
    logic       hwRstSyncN;
    logic       stbyPinSyncN;
    logic       strapSync;
    logic       tglSeen_q;

    // Active-low pins enter inverted so cleared flops read as idle; else
    // reset release would fake a pin reset and a standby pulse
    twc_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .asyncIn ({frameTgl, ~resetPinN, ~standby_request_n,
                   serial_clock_polarity_strap}),
        .syncOut (syncOut)
    );

    assign tglSync      = syncOut[3];
    assign hwRstSyncN   = ~syncOut[2];
    assign stbyPinSyncN = ~syncOut[1];
    assign strapSync    = syncOut[0];

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            tglSeen_q <= 1'b0;
        else
            tglSeen_q <= tglSync;
    end

    // ------------------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------------------
    logic      portEn_q;
    wire       frameEvt   = tglSync ^ tglSeen_q;
    wire       frameWrite = frameEvt & portEn_q;
    twc_addr_t frameAddr;
    twc_data_t frameData;
    // Null bits 15 and 14 are dropped
    assign frameAddr = frameWord[`TWC_ADDR_MSB:`TWC_ADDR_LSB];
    assign frameData = frameWord[`TWC_DATA_MSB:0];

    wire ctrl1Hit = frameWrite && (frameAddr == `TWC_CTRL1_ADDR);
    wire swRstHit = ctrl1Hit && frameData[`TWC_CTRL1_SWRST];
    wire hwRstHit = !hwRstSyncN;
    wire resetHit = swRstHit | hwRstHit;

    // ------------------------------------------------------------------------
    // Configuration register file
    // ------------------------------------------------------------------------
    // Standby gates nothing here, so writes land in either standby mode
    twc_data_t cfg_q [`TWC_NUM_REGS];

    genvar gi;
    generate
        for (gi = 0; gi < `TWC_NUM_REGS; gi++)
        begin : g_cfg
            wire hitEntry = frameWrite && (frameAddr == 4'(gi));

            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                    cfg_q[gi] <= `TWC_CFG_DEFAULT;
                else if (resetHit)
                    cfg_q[gi] <= `TWC_CFG_DEFAULT;
                else if (hitEntry)
                    cfg_q[gi] <= frameData;
            end

            assign cfgRegs[gi*10 +: 10] = cfg_q[gi];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Standby
    // ------------------------------------------------------------------------
    wire swStandby = cfg_q[`TWC_CTRL1_ADDR][`TWC_CTRL1_STANDBY_REQUEST_N];
    wire stbyNext  = !stbyPinSyncN | swStandby;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            standbyActive <= 1'b0;
        else
            standbyActive <= stbyNext;
    end

    // ------------------------------------------------------------------------
    // Frame statistics
    // ------------------------------------------------------------------------
    logic [7:0] frameCnt_q;
    twc_frame_t lastFrame_q;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            frameCnt_q  <= 8'h00;
            lastFrame_q <= 16'h0000;
        end
        else if (frameWrite)
        begin
            frameCnt_q  <= frameCnt_q + 8'h01;
            lastFrame_q <= frameWord;
        end
    end

    // ------------------------------------------------------------------------
    // Avalon-MM slave, one wait state on every access
    // ------------------------------------------------------------------------
    twc_bus_state_t busState_q;
    wire            busReq   = avsRead | avsWrite;
    wire            busAck   = busState_q == TWC_BUS_ACK;
    wire            wrCommit = avsWrite & busAck;
    wire            ctrlSel  = avsAddress == `TWC_AVM_CTRL;
    wire            statSel  = avsAddress == `TWC_AVM_STATUS;
    wire            lastSel  = avsAddress == `TWC_AVM_LAST;
    wire            cfgSel   = (avsAddress[7:6] == 2'h1) && (avsAddress[1:0] == 2'h0);
    wire [3:0]      cfgIdx   = avsAddress[5:2];
    wire [31:0]     statWord = {16'h0000, frameCnt_q, 4'h0, strapSync,
                                hwRstHit, !stbyPinSyncN, standbyActive};
    logic [31:0]    rdMux;

    assign avsWaitrequest = busReq & ~busAck;

    always_comb
    begin
        rdMux = 32'h0000_0000;
        if (ctrlSel)
            rdMux = {31'h0000_0000, portEn_q};
        else if (statSel)
            rdMux = statWord;
        else if (lastSel)
            rdMux = {16'h0000, lastFrame_q};
        else if (cfgSel)
            rdMux = {22'h00_0000, cfg_q[cfgIdx]};
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            busState_q <= TWC_BUS_IDLE;
        else if (busReq && !busAck)
            busState_q <= TWC_BUS_ACK;
        else
            busState_q <= TWC_BUS_IDLE;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            avsReaddata <= 32'h0000_0000;
        else if (avsRead && !busAck)
            avsReaddata <= rdMux;
    end

    // Port enable gates acceptance of completed frames only
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            portEn_q <= `TWC_CTRL_RESET;
        else if (wrCommit && ctrlSel)
            portEn_q <= avsWritedata[`TWC_CTRL_PORTEN];
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    sequence s_plain_write;
        frameWrite && !resetHit;
    endsequence

    sequence s_defaults;
        cfgRegs == {`TWC_NUM_REGS{`TWC_CFG_DEFAULT}};
    endsequence

    chk_frame_store: assert property (
        s_plain_write |=> cfg_q[$past(frameAddr)] == $past(frameData))
        else $error("frame data not stored at frame address");

    chk_hw_defaults: assert property (
        hwRstHit |=> s_defaults)
        else $error("reset pin did not restore defaults");

    chk_sw_defaults: assert property (
        swRstHit |=> s_defaults)
        else $error("soft reset did not restore defaults");

    chk_standby_pin: assert property (
        !stbyPinSyncN |=> standbyActive)
        else $error("standby pin low without standby");

    chk_standby_bit: assert property (
        (stbyPinSyncN && !swStandby) |=> !standbyActive)
        else $error("standby held with pin high and bit clear");

    chk_soft_standby: assert property (
        (s_plain_write ##0 ctrl1Hit && frameData[`TWC_CTRL1_STANDBY_REQUEST_N])
        |=> ##1 standbyActive)
        else $error("power-down bit did not enter standby");

    chk_standby_write: assert property (
        (standbyActive ##0 s_plain_write)
        |=> cfg_q[$past(frameAddr)] == $past(frameData))
        else $error("write lost during standby");

    chk_bus_wait: assert property (
        ($rose(busReq) && !busAck) |-> avsWaitrequest ##1 !avsWaitrequest)
        else $error("bus answer not after one wait state");

    chk_port_gate: assert property (
        (frameEvt && !portEn_q) |=> $stable(frameCnt_q))
        else $error("frame counted while port disabled");

    chk_frame_count: assert property (
        frameWrite |=> frameCnt_q == $past(frameCnt_q) + 8'h01)
        else $error("accepted frame not counted");

    chk_last_frame: assert property (
        frameWrite |=> lastFrame_q == $past(frameWord))
        else $error("last frame not captured");

    chk_cfg_hold: assert property (
        (!frameWrite && !resetHit) |=> $stable(cfgRegs))
        else $error("config changed without a frame or reset");

    // ------------------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------------------
    // Read data is loaded in the wait cycle, so each read check looks one edge on
    sequence s_read_take;
        avsRead && !busAck;
    endsequence

    chk_wait_single: assert property (
        avsWaitrequest |=> !avsWaitrequest)
        else $error("more than one wait state");

    chk_wait_idle: assert property (
        !busReq |-> !avsWaitrequest)
        else $error("waitrequest without a request");

    chk_ctrl_write: assert property (
        (avsWrite && !avsWaitrequest && ctrlSel)
        |=> portEn_q == $past(avsWritedata[`TWC_CTRL_PORTEN]))
        else $error("control write not applied");

    chk_ctrl_read: assert property (
        (s_read_take ##0 ctrlSel) |=> avsReaddata == {31'h0000_0000, $past(portEn_q)})
        else $error("control read wrong");

    chk_stat_read: assert property (
        (s_read_take ##0 statSel)
        |=> avsReaddata[0] == $past(standbyActive) && avsReaddata[31:16] == 16'h0000)
        else $error("status read wrong");

    chk_last_read: assert property (
        (s_read_take ##0 lastSel) |=> avsReaddata == {16'h0000, $past(lastFrame_q)})
        else $error("last frame read wrong");

    chk_cfg_read: assert property (
        (s_read_take ##0 cfgSel)
        |=> avsReaddata == {22'h00_0000, $past(cfgRegs[cfgIdx*10 +: 10])})
        else $error("config read wrong");

    chk_unmapped_zero: assert property (
        (s_read_take ##0 !(ctrlSel || statSel || lastSel || cfgSel))
        |=> avsReaddata == 32'h0000_0000)
        else $error("unmapped read not zero");

endmodule // twc_top

// File: verification/twc_host_model.sv
// Host controller model that drives serial write frames into the config port
`timescale 1ns/1ps
module twc_host_model
    import twc_pkg::*;
#(
    parameter real HALF_NS = 80.0
) (
    input  wire logic strap,
    output logic      serialClk,
    output logic      selectN,
    output logic      serialData
);
    initial
    begin
        serialClk  = 1'b0;
        selectN    = 1'b1;
        serialData = 1'b1;
    end

    // ------------------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------------------
    // Sends the first nBits of a frame; fewer than 16 leaves a partial frame
    task automatic send_frame(input twc_addr_t addr, input twc_data_t data, input int nBits);
        twc_frame_t frame;
        frame = {2'b00, addr, data};
        serialClk = strap;
        #(HALF_NS + 3.0);
        selectN = 1'b0;
        #(HALF_NS);
        for (int i = 15; i > 15 - nBits; i--)
        begin
            // Bits past the sixteenth are sent as zeros
            serialData = (i >= 0) ? frame[i] : 1'b0;
            #(HALF_NS);
            serialClk = ~strap;
            #(HALF_NS);
            serialClk = strap;
        end
        #(HALF_NS);
        selectN = 1'b1;
        // Released line shows garbage, never the last bit
        serialData = ~serialData;
    endtask
endmodule // twc_host_model

// File: verification/tb.sv
// Self-checking bench for the three-wire config port
`timescale 1ns/1ps
`include "twc_defines.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("BAD %0t got %h expected %h", $time, (got), (exp)); end end
module tb
    import twc_pkg::*;
;
    logic         clk_sys;
    logic         arst_n;
    logic         serialClk;
    logic         selectN;
    logic         serialData;
    logic         tbStrap;
    logic         resetPinN;
    logic         standbyPinN;
    logic [7:0]   avsAddress;
    logic         avsRead;
    logic         avsWrite;
    logic [31:0]  avsWritedata;
    logic [31:0]  avsReaddata;
    logic         avsWaitrequest;
    logic         standbyActive;
    logic [159:0] cfgRegs;
    logic [31:0]  rdData;
    int           mismatches;
    int           comparisons;

    twc_top u_twc_top (.clk_sys(clk_sys), .arst_n(arst_n), .serialClk(serialClk),
        .selectN(selectN), .serial_write_data(serialData),
        .serial_clock_polarity_strap(tbStrap), .resetPinN(resetPinN),
        .standby_request_n(standbyPinN), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .standbyActive(standbyActive), .cfgRegs(cfgRegs));
    twc_host_model u_twc_host_model (.strap(tbStrap), .serialClk(serialClk),
        .selectN(selectN), .serialData(serialData));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Holds the request until waitrequest is sampled low, then releases it
    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avsAddress   <= a;
        avsWritedata <= d;
        avsWrite     <= wr;
        avsRead      <= ~wr;
        @(posedge clk_sys);
        while (avsWaitrequest !== 1'b0 && n < 50)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 50)
        begin
            mismatches++;
            finish_test();
        end
        rdData = avsReaddata;
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic bus_rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus_xfer(1'b0, a, 32'h0000_0000);
        `CHK(rdData, exp)
    endtask

    // Frame plus settling time for the crossing into the system domain
    task automatic frame(input twc_addr_t a, input twc_data_t d, input int n);
        u_twc_host_model.send_frame(a, d, n);
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic chk_reg(input int i, input twc_data_t exp);
        `CHK(cfgRegs[10*i +: 10], exp)
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic test_reset;
        `CHK(cfgRegs, 160'h0)
        `CHK(standbyActive, 1'b0)
        bus_rd_chk(`TWC_AVM_CTRL, 32'h0000_0001);
        $display("test_reset done");
    endtask

    task automatic test_write;
        frame(4'h5, 10'h2A5, 16);
        chk_reg(5, 10'h2A5);
        chk_reg(4, 10'h000);
        bus_rd_chk(`TWC_AVM_LAST, 32'h0000_16A5);
        bus_xfer(1'b1, `TWC_AVM_CFG_BASE + 8'h14, 32'h0000_03FF);
        bus_rd_chk(`TWC_AVM_CFG_BASE + 8'h14, 32'h0000_02A5);
        bus_rd_chk(8'hFC, 32'h0000_0000);
        frame(4'h5, 10'h155, 10);
        chk_reg(5, 10'h2A5);
        frame(4'h7, 10'h123, 18);
        chk_reg(7, 10'h123);
        $display("test_write done");
    endtask

    task automatic test_strap;
        tbStrap <= 1'b1;
        @(posedge clk_sys);
        frame(4'hF, 10'h3C3, 16);
        chk_reg(15, 10'h3C3);
        bus_xfer(1'b0, `TWC_AVM_STATUS, 32'h0);
        `CHK(rdData[3], 1'b1)
        tbStrap <= 1'b0;
        @(posedge clk_sys);
        frame(4'hE, 10'h001, 16);
        chk_reg(14, 10'h001);
        $display("test_strap done");
    endtask

    task automatic test_standby;
        frame(4'h0, 10'h200, 16);
        `CHK(standbyActive, 1'b1)
        frame(4'h3, 10'h0F0, 16);
        chk_reg(3, 10'h0F0);
        frame(4'h0, 10'h000, 16);
        `CHK(standbyActive, 1'b0)
        standbyPinN <= 1'b0;
        repeat (5) @(posedge clk_sys);
        `CHK(standbyActive, 1'b1)
        bus_xfer(1'b0, `TWC_AVM_STATUS, 32'h0000_0000);
        `CHK(rdData[1:0], 2'b11)
        frame(4'h9, 10'h111, 16);
        chk_reg(9, 10'h111);
        standbyPinN <= 1'b1;
        repeat (5) @(posedge clk_sys);
        `CHK(standbyActive, 1'b0)
        $display("test_standby done");
    endtask

    task automatic test_enable;
        bus_xfer(1'b1, `TWC_AVM_CTRL, 32'h0000_0000);
        frame(4'h2, 10'h0AA, 16);
        chk_reg(2, 10'h000);
        bus_xfer(1'b1, `TWC_AVM_CTRL, 32'h0000_0001);
        frame(4'h2, 10'h0AA, 16);
        chk_reg(2, 10'h0AA);
        $display("test_enable done");
    endtask

    task automatic test_soft_reset;
        frame(4'h0, 10'h100, 16);
        `CHK(cfgRegs, 160'h0)
        $display("test_soft_reset done");
    endtask

    task automatic test_reset_pin;
        frame(4'h6, 10'h3FF, 16);
        chk_reg(6, 10'h3FF);
        resetPinN <= 1'b0;
        repeat (5) @(posedge clk_sys);
        `CHK(cfgRegs, 160'h0)
        bus_xfer(1'b0, `TWC_AVM_STATUS, 32'h0000_0000);
        `CHK(rdData[2:0], 3'b100)
        frame(4'h6, 10'h3FF, 16);
        `CHK(cfgRegs, 160'h0)
        resetPinN <= 1'b1;
        repeat (5) @(posedge clk_sys);
        $display("test_reset_pin done");
    endtask

    // ------------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial
    begin
        mismatches   = 0;
        comparisons  = 0;
        arst_n       = 1'b0;
        tbStrap      = 1'b0;
        resetPinN    = 1'b1;
        standbyPinN  = 1'b1;
        avsAddress   = 8'h00;
        avsRead      = 1'b0;
        avsWrite     = 1'b0;
        avsWritedata = 32'h0000_0000;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        test_reset();
        test_write();
        test_strap();
        test_standby();
        test_enable();
        test_soft_reset();
        test_reset_pin();
        finish_test();
    end

    // 14 frames of about 3 us each; a generous margin above that
    initial
    begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule // tb
